// ---- hdl/toc_cfg.svh ----
/*
  constants of the threshold output controller: register word indices, control field
  positions, reset values and time-base figures.
  assumes inclusion by bare name from the design files.
*/
`ifndef TOC_CFG_SVH
`define TOC_CFG_SVH

// register word indices, one 16-bit word each
`define TOC_REG_CTRL 4'h0
`define TOC_REG_THR1 4'h1
`define TOC_REG_THR2 4'h2
`define TOC_REG_BAND 4'h3
`define TOC_REG_DEVLIM 4'h4
`define TOC_REG_PCTLIM 4'h5
`define TOC_REG_TON 4'h6
`define TOC_REG_TURN_OFF_DELAY 4'h7
`define TOC_REG_PWMLO 4'h8
`define TOC_REG_PWMHI 4'h9
`define TOC_REG_PERIOD 4'hA
`define TOC_REG_MINLOW 4'hB
`define TOC_REG_MINHIGH 4'hC
`define TOC_REG_FDUTY 4'hD
`define TOC_REG_SOURCE 4'hE
`define TOC_REG_STATUS 4'hF
`define TOC_NUM_CFG 15

// control word fields
`define TOC_CTRL_MODE_LSB 0
`define TOC_CTRL_UNIT_MIN 3
`define TOC_CTRL_FRESP_LSB 4
`define TOC_CTRL_PWM_FEN 6
`define TOC_CTRL_USE_FDUTY 7
`define TOC_CTRL_BEEP_AL 8
`define TOC_CTRL_BEEP_OUT 9
`define TOC_CTRL_SER_VAL 10

// status word fields
`define TOC_STAT_RELAY 0
`define TOC_STAT_ALARM 1
`define TOC_STAT_BEEP 2
`define TOC_STAT_PEND 3

// setting limits and reset values
`define TOC_BAND_MAX 16'h03E7
`define TOC_DELAY_MAX 16'h03E7
`define TOC_PERIOD_MAX 16'h270F
`define TOC_PCT_FULL 7'h64
`define TOC_CFG_RST 16'h0000

// time base: one step is 0.1 s, a minute step is 60 of those
`define TOC_CLK_NS 50
`define TOC_STEP_NS 100000000
`define TOC_STEPS_PER_MIN 6'h3C

`endif

// ---- hdl/toc_pkg.sv ----
/*
  types of the threshold output controller.
  assumes the design files name every item as toc_pkg::name.
*/
package toc_pkg;

  // operating mode field of the control word
  typedef enum logic [2:0] {
    TOC_OUTPUT_DISABLED = 3'h0,
    TOC_DIRECT = 3'h1,
    TOC_INVERSE = 3'h2,
    TOC_WIN_INSIDE = 3'h3,
    TOC_WIN_OUTSIDE = 3'h4,
    TOC_PWM_OUTPUT_MODE = 3'h5
  } toc_mode_t;

  // alarm response of the switching modes
  typedef enum logic [1:0] {
    TOC_HOLD_STATE = 2'h0,
    TOC_FORCE_ON = 2'h1,
    TOC_FORCE_OFF = 2'h2
  } toc_fresp_t;

  // signal source selection
  typedef enum logic [1:0] {
    TOC_SRC_INPUT = 2'h0,
    TOC_SRC_REGULATOR = 2'h1,
    TOC_SRC_SERIAL = 2'h2
  } toc_src_t;

  // qualification timer state
  typedef struct packed {
    logic [15:0] count;
  } toc_qual_t;

  // state of the top module
  typedef struct packed {
    logic [14:0][15:0] cfg;
    logic [15:0] rdata;
    logic relay;
    logic led;
    logic beep;
    logic alarm;
    logic key_s1;
    logic key_s2;
    logic key_s3;
    logic [31:0] step_cnt;
    logic [5:0] min_cnt;
    logic step;
    logic min_step;
    logic [15:0] pos;
    logic [15:0] high_len;
  } toc_state_t;

endpackage : toc_pkg

// ---- hdl/toc_qual_if.sv ----
/*
  carrier between the controller and one qualification timer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface toc_qual_if;
  logic tick;         // one tenth-of-unit step
  logic arm;          // condition beyond the border
  logic [15:0] limit; // delay in tenths of the unit
  logic done;         // delay expired while armed
  modport ctl (output tick, output arm, output limit, input done);
  modport tmr (input tick, input arm, input limit, output done);
endinterface : toc_qual_if

// ---- hdl/toc_qual.sv ----
/*
  qualification timer: counts unit steps while the arm condition holds.
  assumes tick is a one-cycle pulse on the common clock.
*/
`timescale 1ns/10ps
module toc_qual (
  input wire logic i_clk,  // system clock
  input wire logic i_srst, // synchronous reset
  toc_qual_if.tmr q        // timer port
);
  `include "toc_cfg.svh"

  toc_pkg::toc_qual_t st;      // registered state
  toc_pkg::toc_qual_t next_st; // next state

  // done as soon as the armed time reaches the limit; zero limit is immediate
  assign q.done = q.arm && (st.count >= q.limit);

  // count while armed, restart on every return inside the border
  always_comb
  begin
    next_st = st;
    if (!q.arm)
    begin
      next_st.count = 16'h0000;
    end
    else if (q.tick && (st.count != 16'hFFFF))
    begin
      next_st.count = st.count + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule : toc_qual

// ---- hdl/toc_top.sv ----
/*
  threshold output controller for one relay or open-collector output: threshold,
  window and pulse modes, qualification delays, alarm response, led and beeper.
  assumes the measured value, regulator figures and range error come from logic on
  i_clk; the key input comes from a pin and is synchronised here.
*/
// Our own choices: the register offsets and the address-and-strobe port.
// How it works
// - direct/inverse single threshold with deadband
// - window inside uses min/max thresholds
// - disabled mode holds output off unless force-on applies
// - deadband 0..999, band twice setting
// - inside deadband previous state kept
// - led lit whenever output closed
// - serial commanded state lost at reset
// - regulator acts on setpoint deviation limit
// - regulator acts on output percent limit
// - both limits nonzero need both
// - turn-on after qualified delay
// - turn-off after qualified delay
// - one selector: seconds or minutes
// - pulse mode ignores threshold settings
// - pulse duty 0% below, 100% above
// - pulse period from cycle length
// - minimum high/low per period
// - alarm: hold, force on, force off
// - pulse alarm: hold or fault duty
// - out of range is alarm except in disabled mode
// - force-on applies even when disabled
// - beeper on alarm or output activation
// - any key silences beeper
`timescale 1ns/10ps
`include "toc_cfg.svh"
module toc_top #(
  parameter int STEP_CYC = `TOC_STEP_NS / `TOC_CLK_NS // clocks per 0.1 s step
) (
  input wire logic i_clk,                 // 20 MHz clock
  input wire logic i_srst,                // synchronous reset, high
  input wire logic [3:0] i_addr,          // register word index
  input wire logic [15:0] i_wdata,        // write data
  input wire logic i_wr,                  // write strobe
  input wire logic i_rd,                  // read strobe
  output logic [15:0] o_rdata,            // read data, cycle after strobe
  input wire logic signed [15:0] i_value, // measured value
  input wire logic signed [15:0] i_first_threshold,  // regulator setpoint
  input wire logic [6:0] i_reg_pct,       // regulator output percent
  input wire logic i_range_err,           // measurement out of range
  input wire logic i_key,                 // any front-panel key, pin
  output logic o_relay,                   // output drive, high closes
  output logic o_led,                     // output indicator
  output logic o_beep,                    // beeper drive
  output logic o_alarm                    // alarm state
);

  toc_pkg::toc_state_t st;      // registered state
  toc_pkg::toc_state_t next_st; // next state
  toc_qual_if q_on ();          // turn-on timer link
  toc_qual_if q_off ();         // turn-off timer link

  // sign-extend a setting to the working width
  function automatic logic signed [17:0] sx(input logic [15:0] x);
    sx = {{2{x[15]}}, x};
  endfunction : sx

  // clamp a band or delay setting to its top value
  function automatic logic [15:0] clip(input logic [15:0] x, input logic [15:0] top);
    clip = (x > top) ? top : x;
  endfunction : clip

  // duty percent of the source between the two pulse limits
  function automatic logic [6:0] duty_of(input logic signed [17:0] v,
                                         input logic signed [17:0] lo,
                                         input logic signed [17:0] hi);
    logic signed [17:0] dn;
    logic signed [17:0] dd;
    logic [31:0] q;
    dn = v - lo;
    dd = hi - lo;
    q = 32'h0000_0000;
    if (v <= lo)
    begin
      duty_of = 7'h00;
    end
    else if (v >= hi)
    begin
      duty_of = `TOC_PCT_FULL;
    end
    else
    begin
      q = ({15'h0000, dn[16:0]} * 32'h0000_0064) / {15'h0000, dd[16:0]};
      duty_of = q[6:0];
    end
  endfunction : duty_of

  // high time of one period with the minimum times applied
  function automatic logic [15:0] high_of(input logic [15:0] per, input logic [6:0] pct,
                                          input logic [15:0] mlow,
                                          input logic [15:0] mhigh);
    logic [31:0] q;
    logic [15:0] h;
    q = ({16'h0000, per} * {25'h0000000, pct}) / 32'h0000_0064;
    h = q[15:0];
    if ((h != 16'h0000) && (h < mhigh))
    begin
      h = 16'h0000;
    end
    if ((h != per) && ((per - h) < mlow))
    begin
      h = per;
    end
    high_of = h;
  endfunction : high_of

  // decoded settings
  toc_pkg::toc_mode_t mode;
  toc_pkg::toc_fresp_t fresp;
  toc_pkg::toc_src_t src;
  logic signed [17:0] v;
  logic signed [17:0] t1;
  logic signed [17:0] t2;
  logic signed [17:0] lo_t;
  logic signed [17:0] hi_t;
  logic signed [17:0] hb;
  logic signed [17:0] dev;
  logic want_on;   // input beyond the turn-on border
  logic want_off;  // input beyond the turn-off border
  logic reg_dev;   // deviation condition met
  logic reg_pct;   // percent condition met
  logic sw_next;   // switching-mode output after qualification
  logic pwm_out;   // pulse-mode output
  logic [6:0] pct; // duty in use

  assign mode = toc_pkg::toc_mode_t'(st.cfg[`TOC_REG_CTRL][`TOC_CTRL_MODE_LSB +: 3]);
  assign fresp = toc_pkg::toc_fresp_t'(st.cfg[`TOC_REG_CTRL][`TOC_CTRL_FRESP_LSB +: 2]);
  assign src = toc_pkg::toc_src_t'(st.cfg[`TOC_REG_SOURCE][1:0]);
  assign v = {{2{i_value[15]}}, i_value};
  assign t1 = sx(st.cfg[`TOC_REG_THR1]);
  assign t2 = sx(st.cfg[`TOC_REG_THR2]);
  assign lo_t = (t1 < t2) ? t1 : t2;
  assign hi_t = (t1 < t2) ? t2 : t1;
  assign hb = sx(clip(st.cfg[`TOC_REG_BAND], `TOC_BAND_MAX));
  assign dev = {{2{i_first_threshold[15]}}, i_first_threshold} - v;

  // regulator conditions; a zero limit leaves its condition out
  assign reg_dev = (st.cfg[`TOC_REG_DEVLIM] == 16'h0000) ||
                   (dev >= sx(st.cfg[`TOC_REG_DEVLIM]));
  assign reg_pct = (st.cfg[`TOC_REG_PCTLIM] == 16'h0000) ||
                   ({9'h000, i_reg_pct} >= st.cfg[`TOC_REG_PCTLIM]);

  // border decode per mode; neither border inside the deadband zone
  always_comb
  begin
    want_on = 1'b0;
    want_off = 1'b0;
    if (src == toc_pkg::TOC_SRC_REGULATOR)
    begin
      want_on = reg_dev && reg_pct && ((st.cfg[`TOC_REG_DEVLIM] != 16'h0000) ||
                (st.cfg[`TOC_REG_PCTLIM] != 16'h0000) || (i_reg_pct != 7'h00));
      want_off = !want_on;
    end
    else
    begin
      case (mode)
        toc_pkg::TOC_DIRECT:
        begin
          want_on = v > (t1 + hb);
          want_off = v < (t1 - hb);
        end
        toc_pkg::TOC_INVERSE:
        begin
          want_on = v < (t1 - hb);
          want_off = v > (t1 + hb);
        end
        toc_pkg::TOC_WIN_INSIDE:
        begin
          want_on = (v > (lo_t + hb)) && (v < (hi_t - hb));
          want_off = (v < (lo_t - hb)) || (v > (hi_t + hb));
        end
        toc_pkg::TOC_WIN_OUTSIDE:
        begin
          want_on = (v < (lo_t - hb)) || (v > (hi_t + hb));
          want_off = (v > (lo_t + hb)) && (v < (hi_t - hb));
        end
        default:
        begin
          want_on = 1'b0;
          want_off = 1'b0;
        end
      endcase
    end
  end

  // qualification timers share one unit step
  assign q_on.tick = st.cfg[`TOC_REG_CTRL][`TOC_CTRL_UNIT_MIN] ? st.min_step : st.step;
  assign q_off.tick = q_on.tick;
  assign q_on.arm = want_on && !st.relay;
  assign q_off.arm = want_off && st.relay;
  assign q_on.limit = clip(st.cfg[`TOC_REG_TON], `TOC_DELAY_MAX);
  assign q_off.limit = clip(st.cfg[`TOC_REG_TURN_OFF_DELAY], `TOC_DELAY_MAX);

  toc_qual u_qual_on (
    .i_clk (i_clk),
    .i_srst (i_srst),
    .q (q_on.tmr)
  );

  toc_qual u_qual_off (
    .i_clk (i_clk),
    .i_srst (i_srst),
    .q (q_off.tmr)
  );

  // switching result: change only on an expired delay, else keep
  assign sw_next = q_on.done ? 1'b1 : (q_off.done ? 1'b0 : st.relay);

  // pulse duty: fault duty during alarm when so chosen
  assign pct = (st.alarm && st.cfg[`TOC_REG_CTRL][`TOC_CTRL_PWM_FEN] &&
                st.cfg[`TOC_REG_CTRL][`TOC_CTRL_USE_FDUTY]) ?
               ((st.cfg[`TOC_REG_FDUTY] > 16'h0064) ? `TOC_PCT_FULL :
                st.cfg[`TOC_REG_FDUTY][6:0]) :
               duty_of(v, sx(st.cfg[`TOC_REG_PWMLO]), sx(st.cfg[`TOC_REG_PWMHI]));
  assign pwm_out = (st.cfg[`TOC_REG_PERIOD] == 16'h0000) ? (pct == `TOC_PCT_FULL) :
                   (st.pos < st.high_len);

  // next state: bus, time base, output selection, beeper
  always_comb
  begin
    next_st = st;
    next_st.step = 1'b0;
    next_st.min_step = 1'b0;
    // register writes; status word is read only
    if (i_wr && (i_addr != `TOC_REG_STATUS))
    begin
      next_st.cfg[i_addr] = i_wdata;
    end
    // read data stand for the one cycle after the strobe
    if (i_rd)
    begin
      if (i_addr == `TOC_REG_STATUS)
      begin
        next_st.rdata = {12'h000, (q_on.arm || q_off.arm), st.beep, st.alarm, st.relay};
      end
      else
      begin
        next_st.rdata = st.cfg[i_addr];
      end
    end
    else
    begin
      next_st.rdata = 16'h0000;
    end
    // 0.1 s step and 0.1 min step
    if (st.step_cnt >= 32'(STEP_CYC - 1))
    begin
      next_st.step_cnt = 32'h0000_0000;
      next_st.step = 1'b1;
      if (st.min_cnt >= (`TOC_STEPS_PER_MIN - 6'h01))
      begin
        next_st.min_cnt = 6'h00;
        next_st.min_step = 1'b1;
      end
      else
      begin
        next_st.min_cnt = st.min_cnt + 6'h01;
      end
    end
    else
    begin
      next_st.step_cnt = st.step_cnt + 32'h0000_0001;
    end
    // pulse period position; duty latched at each period start
    if (st.step)
    begin
      if ((st.pos + 16'h0001) >= clip(st.cfg[`TOC_REG_PERIOD], `TOC_PERIOD_MAX))
      begin
        next_st.pos = 16'h0000;
        next_st.high_len = high_of(clip(st.cfg[`TOC_REG_PERIOD], `TOC_PERIOD_MAX), pct,
                                   st.cfg[`TOC_REG_MINLOW],
                                   st.cfg[`TOC_REG_MINHIGH]);
      end
      else
      begin
        next_st.pos = st.pos + 16'h0001;
      end
    end
    // alarm declared in active modes only
    next_st.alarm = i_range_err && (mode != toc_pkg::TOC_OUTPUT_DISABLED);
    // output selection
    if (i_range_err && (mode != toc_pkg::TOC_PWM_OUTPUT_MODE) &&
        (fresp == toc_pkg::TOC_FORCE_ON))
    begin
      next_st.relay = 1'b1;
    end
    else if (mode == toc_pkg::TOC_OUTPUT_DISABLED)
    begin
      next_st.relay = 1'b0;
    end
    else if (mode == toc_pkg::TOC_PWM_OUTPUT_MODE)
    begin
      if (st.alarm && st.cfg[`TOC_REG_CTRL][`TOC_CTRL_PWM_FEN] &&
          !st.cfg[`TOC_REG_CTRL][`TOC_CTRL_USE_FDUTY])
      begin
        next_st.relay = st.relay;
      end
      else
      begin
        next_st.relay = pwm_out;
      end
    end
    else if (i_range_err && (fresp == toc_pkg::TOC_FORCE_OFF))
    begin
      next_st.relay = 1'b0;
    end
    else if (i_range_err && (fresp == toc_pkg::TOC_HOLD_STATE))
    begin
      next_st.relay = st.relay;
    end
    else if (src == toc_pkg::TOC_SRC_SERIAL)
    begin
      next_st.relay = st.cfg[`TOC_REG_CTRL][`TOC_CTRL_SER_VAL];
    end
    else
    begin
      next_st.relay = sw_next;
    end
    next_st.led = next_st.relay;
    // key synchroniser and press edge
    next_st.key_s1 = i_key;
    next_st.key_s2 = st.key_s1;
    next_st.key_s3 = st.key_s2;
    if (st.key_s2 && !st.key_s3)
    begin
      next_st.beep = 1'b0;
    end
    // a new cause in the same cycle as a key press still sounds
    if ((next_st.alarm && !st.alarm && st.cfg[`TOC_REG_CTRL][`TOC_CTRL_BEEP_AL]) ||
        (next_st.relay && !st.relay && st.cfg[`TOC_REG_CTRL][`TOC_CTRL_BEEP_OUT]))
    begin
      next_st.beep = 1'b1;
    end
  end

  // state register; reset drops every setting and the serial state
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign o_rdata = st.rdata;
  assign o_relay = st.relay;
  assign o_led = st.led;
  assign o_beep = st.beep;
  assign o_alarm = st.alarm;

endmodule : toc_top

// ---- tb/toc_top_properties.sv ----
/*
  port checker of the threshold output controller.
  assumes a bind onto toc_top and a single clock domain.
*/
`timescale 1ns/10ps
module toc_top_properties (
  input wire logic i_clk, // clock
  input wire logic i_srst, // reset, high
  input wire logic [3:0] i_addr, // word index
  input wire logic [15:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [15:0] o_rdata, // read data
  input wire logic signed [15:0] i_value, // measured value
  input wire logic signed [15:0] i_first_threshold, // setpoint
  input wire logic [6:0] i_reg_pct, // regulator percent
  input wire logic i_range_err, // range error
  input wire logic i_key, // key pin
  input wire logic o_relay, // output drive
  input wire logic o_led, // indicator
  input wire logic o_beep, // beeper
  input wire logic o_alarm // alarm
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // no cause to start the beeper
  sequence quiet_s;
    !$rose(o_alarm) && !$rose(o_relay);
  endsequence
  // key press seen at the pin
  sequence key_s;
    $rose(i_key);
  endsequence
  a_led_follows_out: assert property (o_led == o_relay)
    else $error("led differs from output");
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_status_mirrors: assert property ($past(i_rd) && $past(i_addr) == 4'hF
    |-> o_rdata[2:0] == $past({o_beep, o_alarm, o_relay}))
    else $error("status word differs from pins");
  a_alarm_has_cause: assert property (o_alarm |-> $past(i_range_err))
    else $error("alarm without range error");
  a_beep_has_cause: assert property ($rose(o_beep) |-> $rose(o_alarm) || $rose(o_relay))
    else $error("beeper started without cause");
  a_key_silences: assert property (key_s ##1 quiet_s [*4] |-> !o_beep)
    else $error("beeper still on after key");
  a_beep_stops_key: assert property ($fell(o_beep)
    |-> $past(i_key, 2) || $past(i_key, 3) || $past(i_key, 4))
    else $error("beeper stopped without key");
  a_reset_clears: assert property ($fell(i_srst) |-> !o_relay && !o_beep && !o_alarm)
    else $error("outputs not cleared by reset");
endmodule : toc_top_properties

bind toc_top toc_top_properties chk_u (.i_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_value, .i_first_threshold, .i_reg_pct, .i_range_err, .i_key, .o_relay, .o_led,
  .o_beep, .o_alarm);

// ---- tb/toc_load_model.sv ----
/*
  load on the relay or open-collector output: counts energised cycles and closures.
  assumes the drive is a registered level on the same clock.
*/
`timescale 1ns/10ps
module toc_load_model (
  input wire logic i_clk, // clock
  input wire logic i_drive, // output drive, high closes
  input wire logic i_clr, // clears both counts
  output logic [15:0] o_on_cycles, // cycles energised
  output logic [15:0] o_closures // closures seen
);
  logic last; // drive one cycle ago
  // load follows the drive; a closure is a rising drive
  always_ff @(posedge i_clk)
  begin
    last <= i_drive;
    if (i_clr)
    begin
      o_on_cycles <= 16'h0000;
      o_closures <= 16'h0000;
    end
    else
    begin
      o_on_cycles <= o_on_cycles + 16'(i_drive);
      o_closures <= o_closures + 16'(i_drive && !last);
    end
  end
endmodule : toc_load_model

// ---- tb/tb_top.sv ----
/*
  testbench of the threshold output controller: register bus, switching modes, delays,
  alarm response, beeper and pulse mode.
  assumes the time step shortened to 4 clocks per tenth of a second.
*/
`timescale 1ns/10ps
module tb_top;
  logic i_clk, i_srst, i_wr, i_rd, i_range_err, i_key, clr, rd_d; // bench drives
  logic [3:0] i_addr; // word index
  logic [15:0] i_wdata, o_rdata, on_cyc, clos, r; // bus and load counts
  logic signed [15:0] i_value, i_first_threshold; // analogue figures
  logic [6:0] i_reg_pct; // regulator percent
  logic o_relay, o_led, o_beep, o_alarm; // design outputs
  logic [15:0] exp_q[$], msk_q[$]; // noted read results
  int failures, tests_run, cyc; // counters
  toc_top #(.STEP_CYC(4)) dut_u (.i_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_value, .i_first_threshold, .i_reg_pct, .i_range_err, .i_key, .o_relay, .o_led,
    .o_beep, .o_alarm);
  toc_load_model load_u (.i_clk, .i_drive(o_relay), .i_clr(clr), .o_on_cycles(on_cyc),
    .o_closures(clos));
  // clock of 50 ns
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // compares one value under a mask
  task automatic chk(input logic [15:0] got, input logic [15:0] e, input logic [15:0] m);
    tests_run++;
    if ((got & m) !== (e & m))
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk
  // compares a count against a band
  task automatic near(input logic [15:0] got, input int lo, input int hi);
    tests_run++;
    if (!(got >= 16'(lo) && got <= 16'(hi)))
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, 16'(lo));
    end
  endtask : near
  // verdict and end of run
  task automatic tally_and_finish;
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // one write cycle, then a quiet cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  // one read cycle; the expected word is noted for the monitor
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask : rd
  // drive a value, wait, read relay, alarm and beep bits
  task automatic step(input logic signed [15:0] v, input int n, input logic [15:0] e);
    i_value <= v;
    repeat (n) @(posedge i_clk);
    rd(4'hF, e, 16'h0007);
  endtask : step
  // switching setup: control, thresholds, deadband, delays
  task automatic cfg(input logic [15:0] c, input logic [15:0] t1, input logic [15:0] t2,
    input logic [15:0] b, input logic [15:0] ton, input logic [15:0] turn_off_delay);
    wr(4'h0, c);
    wr(4'h1, t1);
    wr(4'h2, t2);
    wr(4'h3, b);
    wr(4'h6, ton);
    wr(4'h7, turn_off_delay);
  endtask : cfg
  // measure load time and closures over ten pulse periods
  task automatic duty(input logic signed [15:0] v, input int lo, input int hi,
    input int clo, input int chi);
    i_value <= v;
    repeat (80) @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    repeat (400) @(posedge i_clk);
    near(on_cyc, lo, hi);
    near(clos, clo, chi);
  endtask : duty
  // read data stands in the cycle after the strobe
  always @(posedge i_clk) rd_d <= i_rd;
  always @(negedge i_clk)
    if (rd_d === 1'b1 && exp_q.size() > 0)
      chk(o_rdata, exp_q.pop_front(), msk_q.pop_front());
  // guard against a hang
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  initial
  begin
    {i_wr, i_rd, i_range_err, i_key, clr} = 5'h00;
    {i_addr, i_wdata, i_value, i_first_threshold, i_reg_pct} = '0;
    i_srst = 1'b1;
    r = 16'($urandom(32'h4538f402));
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    for (int i = 0; i < 16; i++) rd(4'(i), 16'h0000, 16'hFFFF);
    for (int i = 1; i < 13; i++)
    begin
      r = 16'($urandom_range(999));
      wr(4'(i), r);
      rd(4'(i), r, 16'hFFFF);
    end
    wr(4'h3, 16'hFFFF);
    rd(4'h3, 16'hFFFF, 16'hFFFF);
    wr(4'hF, 16'hFFFF);
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'h0000);
    cfg(16'h0001, 16'd100, 16'd0, 16'd5, 16'd0, 16'd0);
    step(105, 4, 16'h0000);
    step(106, 4, 16'h0001);
    step(95, 4, 16'h0001);
    step(94, 4, 16'h0000);
    cfg(16'h0002, 16'd100, 16'd0, 16'd5, 16'd0, 16'd0);
    step(106, 4, 16'h0000);
    step(94, 4, 16'h0001);
    cfg(16'h0003, 16'd200, 16'd100, 16'd5, 16'd0, 16'd0);
    step(150, 4, 16'h0001);
    step(94, 4, 16'h0000);
    cfg(16'h0001, 16'd100, 16'd0, 16'd0, 16'd3, 16'd2);
    step(110, 2, 16'h0000);
    step(110, 20, 16'h0001);
    step(90, 20, 16'h0000);
    step(110, 5, 16'h0000);
    step(100, 2, 16'h0000);
    step(110, 5, 16'h0000);
    step(110, 20, 16'h0001);
    step(90, 3, 16'h0001);
    step(90, 20, 16'h0000);
    cfg(16'h0009, 16'd100, 16'd0, 16'd0, 16'd2, 16'd0);
    step(110, 200, 16'h0000);
    step(110, 300, 16'h0001);
    cfg(16'h0010, 16'd100, 16'd0, 16'd0, 16'd0, 16'd0);
    i_range_err <= 1'b1;
    step(0, 4, 16'h0001);
    wr(4'h0, 16'h0021);
    step(110, 4, 16'h0002);
    i_range_err <= 1'b0;
    step(110, 4, 16'h0001);
    wr(4'h0, 16'h0001);
    i_range_err <= 1'b1;
    step(110, 4, 16'h0003);
    i_range_err <= 1'b0;
    wr(4'h0, 16'h0201);
    step(90, 4, 16'h0000);
    step(110, 4, 16'h0005);
    i_key <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_key <= 1'b0;
    step(110, 4, 16'h0001);
    wr(4'h0, 16'h0101);
    i_range_err <= 1'b1;
    step(110, 4, 16'h0007);
    i_key <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_key <= 1'b0;
    step(110, 4, 16'h0003);
    i_range_err <= 1'b0;
    wr(4'h8, 16'd0);
    wr(4'h9, 16'd100);
    wr(4'hA, 16'd10);
    wr(4'hB, 16'd0);
    wr(4'hC, 16'd0);
    wr(4'h0, 16'h0005);
    duty(200, 395, 401, 0, 1);
    duty(-5, 0, 0, 0, 0);
    duty(50, 160, 240, 9, 11);
    wr(4'hC, 16'd8);
    duty(50, 0, 0, 0, 0);
    wr(4'hC, 16'd0);
    wr(4'hD, 16'd100);
    wr(4'h0, 16'h00C5);
    i_range_err <= 1'b1;
    duty(-5, 395, 401, 0, 1);
    i_range_err <= 1'b0;
    cfg(16'h0001, 16'd100, 16'd0, 16'd0, 16'd0, 16'd0);
    wr(4'hE, 16'h0001);
    wr(4'h4, 16'd10);
    wr(4'h5, 16'd50);
    i_first_threshold <= 16'sd100;
    i_reg_pct <= 7'd60;
    step(85, 4, 16'h0001);
    i_reg_pct <= 7'd40;
    step(85, 4, 16'h0000);
    i_reg_pct <= 7'd60;
    step(95, 4, 16'h0000);
    wr(4'hE, 16'h0002);
    wr(4'h0, 16'h0401);
    step(0, 4, 16'h0001);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    step(0, 4, 16'h0000);
    rd(4'h0, 16'h0000, 16'hFFFF);
    repeat (2) @(posedge i_clk);
    tally_and_finish();
  end
endmodule : tb_top
